// File: pfm_pkg.sv
// Package of constants for the point-of-load fault protection manager
`default_nettype none
package pfm_pkg;
    localparam logic [4:0] PROT_CONFIG_ADDR    = 5'h00;
    localparam logic [4:0] FAULT_FLAGS_ADDR    = 5'h16;
    localparam logic [7:0] PROT_CONFIG_RESET   = 8'h43;
    localparam logic [7:0] FAULT_FLAGS_RESET   = 8'hfe;
    localparam int RF_CHECK_BIT    = 7;
    localparam int PHASE_CHECK_BIT = 6;
    localparam int RF_LATCH_BIT    = 5;
    localparam int HEAT_LATCH_BIT  = 4;
    localparam int CL_LATCH_BIT    = 3;
    localparam int LV_LATCH_BIT    = 2;
    localparam int HV_LATCH_BIT    = 1;
    localparam int PH_LATCH_BIT    = 0;
    localparam int ST_HEAT_WARN    = 7;
    localparam int ST_IN_WINDOW    = 6;
    localparam int ST_RAMP_FOLLOW  = 5;
    localparam int ST_HEAT         = 4;
    localparam int ST_CURRENT      = 3;
    localparam int ST_LOW_V        = 2;
    localparam int ST_HIGH_V       = 1;
    localparam int CLK_MHZ         = 100;
    localparam int RETRY_MS        = 130;
    localparam int RETRY_CYCLES    = RETRY_MS * 1000 * CLK_MHZ;
    // Turn-off style encodings
    localparam logic [1:0] OFF_SEQUENCED = 2'h0;
    localparam logic [1:0] OFF_CRITICAL  = 2'h1;
    localparam logic [1:0] OFF_EMERGENCY = 2'h2;
    typedef enum logic [1:0] {PFM_RUN, PFM_OFF, PFM_WAIT} pfm_state_type;
endpackage : pfm_pkg
`default_nettype wire

// File: pfm_protection.sv
// Fault detection, turn-off control, retry and status registers of the converter
//
// Contract
// RULE1: In steady state, output below low limit without current fault trips sequenced off.
// RULE2: Temperature above 130 C trips heat fault with regular turn-off.
// RULE3: Non-latching heat fault restarts once temperature is below 120 C warning.
// RULE4: During ramp-up, tracking error above 250 mV trips ramp-follow fault, fast off.
// RULE5: Config bit 7 enables ramp-follow checking.
// RULE6: Ramp-follow checking stops at power good and stays off through margining.
// RULE7: Low and high limits track the targeted nominal or margin setpoint.
// RULE8: Above prebias, output over high limit trips high-voltage error, emergency off.
// RULE9: High limit programmable 110-130 percent, at least 0.5 V, 0.25 V above setpoint.
// RULE10: Non-latching faults retry every 130 ms until the condition clears.
// RULE11: Latching faults stay off; restart after 130 ms once cleared and released.
// RULE12: Config bits 5..0 select latching per protection, 1 latching.
// RULE13: Config bit 6 enables phase-voltage error detection.
// RULE14: Heat, low and high voltage have selectable sequenced, critical or emergency off.
// RULE15: Active conditions read as 0 in the status register.
// RULE16: Writing 1 to a fault bit of the status register clears that latched fault.
// RULE17: Status bits 7..1: warning, power good, ramp, heat, current, low, high.
// RULE18: The power manager reads status and publishes it to monitoring software.
// RULE19: Latching and propagation are configured per protection independently.
// RULE20: Above prebias, current at limit trips current-limit fault with fast off.
// RULE21: Comparisons arrive as synchronous inputs; retry interval counted on mclk.
`default_nettype none
module pfm_protection
    import pfm_pkg::*;
#(
    parameter int RETRY_COUNT = RETRY_CYCLES
) (
    input  wire logic       mclk,               // 100 MHz clock
    input  wire logic       reset_n,            // Asynchronous reset, active low
    input  wire logic [4:0] reg_addr,           // Register address
    input  wire logic       reg_wr,             // Register write strobe
    input  wire logic       reg_rd,             // Register read strobe
    input  wire logic [7:0] reg_wdata,          // Register write data
    output logic      [7:0] reg_rdata,          // Register read data
    input  wire logic       turn_on_cmd,        // Turn-on command level
    input  wire logic       ramping_up,         // Output is ramping up
    input  wire logic       steady_state,       // Output at steady state
    input  wire logic       above_prebias,      // Output above prebias level
    input  wire logic       output_in_window,   // Power good, high = good
    input  wire logic       below_low_limit,    // Output below scaled low limit
    input  wire logic       above_high_limit,   // Output above scaled high limit
    input  wire logic       current_at_limit,   // Current reached limit
    input  wire logic       temp_over_130,      // Temperature above 130 C
    input  wire logic       temp_over_120,      // Temperature above 120 C warning
    input  wire logic       track_err_250mv,    // Tracking difference above 250 mV
    input  wire logic       phase_error,        // Phase voltage error
    input  wire logic [1:0] heat_off_style,     // Heat turn-off style
    input  wire logic [1:0] low_v_off_style,    // Low-voltage turn-off style
    input  wire logic [1:0] high_v_off_style,   // High-voltage turn-off style
    output logic            converter_enable,   // Converter allowed to run
    output logic            ramp_down_req,      // Sequenced ramp-down request
    output logic            high_side_off,      // Force high-side switch off
    output logic            low_side_on,        // Force low-side switch on
    output logic            phase_fault         // Phase voltage error tripped, held until reset
);
    // Threshold scaling and the high limit clamp live in the analogue monitor [RULE7] [RULE9]
    pfm_state_type state_reg, state_next;
    logic [7:0]  config_reg;
    logic [5:0]  latched_reg;     // Ramp, heat, current, low, high, phase
    logic [31:0] retry_reg;
    logic        rf_armed_reg;
    logic [1:0]  style_reg, style_next;
    logic        write_cfg, write_st;
    logic        trip_rf, trip_heat, trip_cl, trip_lv, trip_hv, trip_ph;
    logic [5:0]  trip_vec, clear_vec, cond_vec;
    logic        any_trip, cond_clear, retry_done, all_nonlatch, latched_any;
    logic        released, was_on_reg;

    assign write_cfg      = reg_wr && (reg_addr == PROT_CONFIG_ADDR);
    assign write_st       = reg_wr && (reg_addr == FAULT_FLAGS_ADDR);
    // Ramp-follow armed from start of ramp until power good [RULE6]
    assign trip_rf   = config_reg[RF_CHECK_BIT] && rf_armed_reg && ramping_up
                       && track_err_250mv; // [RULE4] [RULE5]
    assign trip_heat = temp_over_130; // [RULE2]
    assign trip_cl   = above_prebias && current_at_limit; // [RULE20]
    assign trip_lv   = steady_state && below_low_limit && !current_at_limit; // [RULE1]
    assign trip_hv   = above_prebias && above_high_limit; // [RULE8]
    assign trip_ph   = config_reg[PHASE_CHECK_BIT] && phase_error; // [RULE13]
    assign trip_vec  = {trip_rf, trip_heat, trip_cl, trip_lv, trip_hv, trip_ph};
    assign any_trip  = (state_reg == PFM_RUN) && converter_enable && (|trip_vec);
    // Heat clears at warning threshold, others when their trip input drops [RULE3]
    assign cond_vec  = {track_err_250mv, temp_over_120, current_at_limit,
                        below_low_limit, above_high_limit, trip_ph};
    assign cond_clear   = ~|(cond_vec & latched_reg);
    assign clear_vec    = write_st ? {reg_wdata[ST_RAMP_FOLLOW], reg_wdata[ST_HEAT],
                          reg_wdata[ST_CURRENT], reg_wdata[ST_LOW_V],
                          reg_wdata[ST_HIGH_V], 1'b0} : 6'h00; // [RULE16]
    assign latched_any  = |(latched_reg & config_reg[5:0]); // [RULE12] [RULE19]
    assign all_nonlatch = !latched_any;
    assign released     = turn_on_cmd && !was_on_reg;
    assign retry_done   = (retry_reg >= RETRY_COUNT[31:0] - 32'h1); // [RULE21]

    always_comb begin
        style_next = style_reg;
        if (trip_rf || trip_cl)
            style_next = OFF_CRITICAL; // [RULE4] [RULE20]
        else if (trip_hv)
            style_next = high_v_off_style; // [RULE14] [RULE8]
        else if (trip_lv)
            style_next = low_v_off_style; // [RULE14]
        else if (trip_heat)
            style_next = heat_off_style; // [RULE14]
        else if (trip_ph)
            style_next = OFF_CRITICAL;
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PFM_RUN: begin
                if (any_trip)
                    state_next = PFM_OFF;
            end
            PFM_OFF: begin
                if (retry_done)
                    state_next = PFM_WAIT; // [RULE10] [RULE11]
            end
            PFM_WAIT: begin
                if (cond_clear && (all_nonlatch || released))
                    state_next = PFM_RUN; // [RULE10] [RULE11]
            end
            default: state_next = PFM_RUN;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= PFM_RUN;
            style_reg <= OFF_SEQUENCED;
            was_on_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            was_on_reg <= turn_on_cmd;
            if (any_trip)
                style_reg <= style_next;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            retry_reg <= 32'h0;
        else if (state_reg != PFM_OFF)
            retry_reg <= 32'h0;
        else if (!retry_done)
            retry_reg <= retry_reg + 32'h1; // [RULE21]
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            rf_armed_reg <= 1'b1;
        else if (output_in_window)
            rf_armed_reg <= 1'b0; // [RULE6]
        else if (!converter_enable)
            rf_armed_reg <= 1'b1;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            latched_reg <= 6'h00;
        else
            latched_reg <= (latched_reg & ~clear_vec)
                           | (any_trip ? trip_vec : 6'h00); // [RULE16]
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            config_reg <= PROT_CONFIG_RESET;
        else if (write_cfg)
            config_reg <= reg_wdata; // [RULE5] [RULE12] [RULE13]
    end

    // Status: active warning and latched faults read 0, power good reads 1, bit 0 reserved reads 0 [RULE15] [RULE17]
    logic [7:0] status_word;
    assign status_word = {!temp_over_120, output_in_window, !latched_reg[5],
                          !latched_reg[4], !latched_reg[3], !latched_reg[2],
                          !latched_reg[1], 1'b0};

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else if (reg_rd && reg_addr == PROT_CONFIG_ADDR)
            reg_rdata <= config_reg;
        else if (reg_rd && reg_addr == FAULT_FLAGS_ADDR)
            reg_rdata <= status_word; // [RULE15]
        else if (reg_rd)
            reg_rdata <= 8'h00;
    end

    // Switch control from state and captured style [RULE14]
    logic off_now;
    assign off_now = (state_reg != PFM_RUN);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            converter_enable <= 1'b0;
            ramp_down_req    <= 1'b0;
            high_side_off    <= 1'b1;
            low_side_on      <= 1'b0;
            phase_fault      <= 1'b0;
        end else begin
            converter_enable <= !off_now && !any_trip && turn_on_cmd;
            ramp_down_req    <= (off_now || any_trip)
                                && (any_trip ? style_next : style_reg) == OFF_SEQUENCED;
            high_side_off    <= (off_now || any_trip)
                                && (any_trip ? style_next : style_reg) != OFF_SEQUENCED;
            low_side_on      <= (off_now || any_trip)
                                && (any_trip ? style_next : style_reg) == OFF_EMERGENCY;
            // Shows the phase error on the same edge as the switch outputs
            phase_fault      <= latched_reg[0] || (any_trip && trip_ph); // [RULE13]
        end
    end
endmodule // pfm_protection
`default_nettype wire

// File: pfm_prot_sva.sv
// Port assertions for the protection manager
`default_nettype none
module pfm_prot_sva
    import pfm_pkg::*;
#(parameter int RETRY_COUNT = 20) (
    input wire logic mclk, reset_n, reg_wr, reg_rd, turn_on_cmd, steady_state, above_prebias,
    input wire logic ramping_up, below_low_limit, above_high_limit, current_at_limit,
    input wire logic temp_over_130, temp_over_120, track_err_250mv, phase_error, output_in_window,
    input wire logic converter_enable, ramp_down_req, high_side_off, low_side_on, phase_fault,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    input wire logic [1:0] low_v_off_style, high_v_off_style
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  cfg_reg;
    logic [31:0] off_cnt_reg;
    logic        armed_reg;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Shadow of the configuration and length of each off period
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_reg     <= PROT_CONFIG_RESET;
            off_cnt_reg <= '0;
            armed_reg   <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == PROT_CONFIG_ADDR) cfg_reg <= reg_wdata;
            off_cnt_reg <= converter_enable ? '0 : off_cnt_reg + 32'h1;
            armed_reg   <= armed_reg | converter_enable;
        end
    end
    sequence quiet;
        !above_high_limit && !current_at_limit && !temp_over_130 && !phase_error;
    endsequence
    sequence lv_cause;
        converter_enable && steady_state && below_low_limit && !track_err_250mv;
    endsequence
    lv_seq_a: assert property (lv_cause ##0 quiet ##0 low_v_off_style == OFF_SEQUENCED
        |=> !converter_enable && ramp_down_req) else $error("Low voltage trip wrong");
    heat_off_a: assert property (converter_enable && temp_over_130 |=> !converter_enable)
        else $error("Heat trip missing");
    hv_emerg_a: assert property (converter_enable && above_prebias && above_high_limit
        && !current_at_limit && !temp_over_130 && !phase_error && !below_low_limit
        && !track_err_250mv && high_v_off_style == OFF_EMERGENCY
        |=> high_side_off && low_side_on) else $error("High voltage trip wrong");
    cl_fast_a: assert property (converter_enable && above_prebias && current_at_limit
        && !above_high_limit |=> !converter_enable && high_side_off && !low_side_on)
        else $error("Current trip wrong");
    rf_gate_a: assert property (converter_enable && turn_on_cmd && ramping_up
        && track_err_250mv && !cfg_reg[RF_CHECK_BIT] && !below_low_limit ##0 quiet
        |=> converter_enable) else $error("Disabled ramp check tripped");
    phase_on_a: assert property (converter_enable && cfg_reg[PHASE_CHECK_BIT]
        && phase_error |=> phase_fault && !converter_enable) else $error("Phase trip missing");
    retry_gap_a: assert property ($rose(converter_enable) && armed_reg
        |-> off_cnt_reg >= RETRY_COUNT) else $error("Restart came too early");
    status_live_a: assert property (reg_rd && reg_addr == FAULT_FLAGS_ADDR
        |=> reg_rdata[ST_HEAT_WARN] == !$past(temp_over_120) && !reg_rdata[0]
        && reg_rdata[ST_IN_WINDOW] == $past(output_in_window)) else $error("Status live bits");
    cfg_read_a: assert property (reg_rd && reg_addr == PROT_CONFIG_ADDR
        |=> reg_rdata == $past(cfg_reg)) else $error("Config readback wrong");
endmodule // pfm_prot_sva
`default_nettype wire

// File: pfm_mgr_model.sv
// Power manager model driving the register strobes
`default_nettype none
module pfm_mgr_model (
    input  wire logic       mclk,      // Clock
    output logic      [4:0] reg_addr,  // Register address
    output logic            reg_wr,    // Write strobe
    output logic            reg_rd,    // Read strobe
    output logic      [7:0] reg_wdata  // Write data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
    // Data is scrambled after the strobe so a stale byte is never taken as live
    task automatic write_reg(input logic [4:0] addr, input logic [7:0] data);
        @(negedge mclk);
        {reg_addr, reg_wdata, reg_wr} = {addr, data, 1'b1};
        @(negedge mclk);
        {reg_wdata, reg_wr} = {~data, 1'b0};
    endtask
    task automatic read_reg(input logic [4:0] addr);
        @(negedge mclk);
        {reg_addr, reg_rd} = {addr, 1'b1};
        @(negedge mclk);
        reg_rd = 1'b0;
    endtask
endmodule // pfm_mgr_model
`default_nettype wire

// File: tb_pfm_protection.sv
// Self-checking bench of the protection manager
`default_nettype none
`define CHK(n, e, g) check_val(n, e, g)
module tb_pfm_protection;
    timeunit 1ns;
    timeprecision 1ps;
    import pfm_pkg::*;
    logic        mclk, reset_n, reg_wr, reg_rd, turn_on_cmd, ramping_up, steady_state, rd_d;
    logic        above_prebias, output_in_window, below_low_limit, above_high_limit;
    logic        current_at_limit, temp_over_130, temp_over_120, track_err_250mv, phase_error;
    logic        converter_enable, ramp_down_req, high_side_off, low_side_on, phase_fault;
    logic [4:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [1:0]  heat_off_style, low_v_off_style, high_v_off_style, sty;
    logic [31:0] rnd = 32'h0fe2;
    logic [4:0]  off_tab [3] = '{5'h08, 5'h04, 5'h06};
    int          failures = 0, total_checks = 0;
    logic [7:0]  exp_q [$];
    event        snap_ev;
    wire logic [4:0] outs = {converter_enable, ramp_down_req, high_side_off, low_side_on, phase_fault};
    pfm_protection #(.RETRY_COUNT(20)) u_pfm_protection (.*);
    pfm_mgr_model u_pfm_mgr_model (.*);
    always #5 mclk = ~mclk;
    always @(posedge mclk) rd_d <= reg_rd;
    // Oldest expectation against the read data or the switch outputs
    always @(negedge mclk) if (rd_d) `CHK("reg_rdata", exp_q.pop_front(), reg_rdata);
    always @(snap_ev) `CHK("outputs", exp_q.pop_front(), {3'h0, outs});
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic check_val(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic expect_out(input logic [4:0] e);
        exp_q.push_back({3'h0, e});
        -> snap_ev;
    endtask
    task automatic expect_rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_pfm_mgr_model.read_reg(a);
    endtask
    task automatic wait_en();
        for (int i = 0; i < 200; i++) begin
            @(negedge mclk);
            if (converter_enable === 1'b1) return;
        end
        failures++;
        results();
    endtask
    task automatic set_cause(input int k, input logic v);
        case (k)
            0: below_low_limit = v;
            1: {temp_over_130, temp_over_120} = {v, v | temp_over_120};
            2: above_high_limit = v;
            3: current_at_limit = v;
            default: track_err_250mv = v;
        endcase
    endtask
    // Trip, check the off state and flags, optionally hold off, then clear and restart
    task automatic trip(input int k, input logic [4:0] eo, input logic [7:0] es, input bit held);
        @(negedge mclk);
        set_cause(k, 1'b1);
        @(negedge mclk);
        expect_out(eo);
        expect_rd(FAULT_FLAGS_ADDR, es);
        set_cause(k, 1'b0);
        if (held) begin
            repeat (60) @(negedge mclk);
            expect_out(eo);
        end
        temp_over_120 = 1'b0;
        u_pfm_mgr_model.write_reg(FAULT_FLAGS_ADDR, 8'h3e);
        wait_en();
        expect_out(5'h10);
    endtask
    initial begin
        {mclk, reset_n, turn_on_cmd, ramping_up, below_low_limit, above_high_limit} = '0;
        {current_at_limit, temp_over_130, temp_over_120, track_err_250mv, phase_error} = '0;
        {steady_state, above_prebias, output_in_window} = 3'h7;
        {heat_off_style, high_v_off_style, low_v_off_style} = {OFF_CRITICAL, OFF_EMERGENCY, 2'h0};
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        expect_rd(PROT_CONFIG_ADDR, PROT_CONFIG_RESET);
        expect_rd(FAULT_FLAGS_ADDR, 8'hfe);
        rnd = xs(rnd);
        u_pfm_mgr_model.write_reg(5'h05, rnd[7:0]);
        expect_rd(5'h05, 8'h00);
        expect_rd(PROT_CONFIG_ADDR, PROT_CONFIG_RESET);
        turn_on_cmd = 1'b1;
        wait_en();
        for (int s = 0; s < 3; s++) begin
            rnd = xs(rnd);
            sty = 2'((s + rnd[3:0]) % 3);
            low_v_off_style = sty;
            trip(0, off_tab[sty], 8'hfa, 1'b0);
        end
        trip(1, 5'h04, 8'h6e, 1'b1);
        trip(2, 5'h06, 8'hfc, 1'b1);
        // Power good low through the next off period re-arms the ramp-follow check
        output_in_window = 1'b0;
        trip(3, 5'h04, 8'hb6, 1'b0);
        {output_in_window, ramping_up, track_err_250mv} = 3'h3;
        u_pfm_mgr_model.write_reg(PROT_CONFIG_ADDR, 8'h43);
        expect_out(5'h10);
        track_err_250mv = 1'b0;
        u_pfm_mgr_model.write_reg(PROT_CONFIG_ADDR, 8'hc3);
        trip(4, 5'h04, 8'h9e, 1'b0);
        output_in_window = 1'b1;
        @(negedge mclk);
        track_err_250mv = 1'b1;
        @(negedge mclk);
        expect_out(5'h10);
        {track_err_250mv, ramping_up, phase_error} = 3'h1;
        @(negedge mclk);
        expect_out(5'h05);
        @(negedge mclk);
        results();
    end
endmodule // tb_pfm_protection
bind pfm_protection pfm_prot_sva #(.RETRY_COUNT(RETRY_COUNT)) u_pfm_prot_sva (.*);
`default_nettype wire
